// >>> hdl/srap_pkg.sv
// ************************************************************
// serial register access port: shared constants
// ************************************************************
package srap_pkg;

  // frame geometry
  localparam int INSTR_BITS = 16; // instruction phase length in rising edges
  localparam int BYTE_BITS = 8; // data bits per register byte
  localparam int RW_BIT = 15; // direction flag inside the instruction word
  localparam logic [3:0] INSTR_LAST = 4'hf; // bit counter value of the last instruction bit
  localparam logic [3:0] BYTE_LAST = 4'h7; // bit counter value of the last data bit

  // register addresses
  localparam logic [14:0] ADDR_CFG = 15'h000; // port configuration byte
  localparam logic [14:0] ADDR_UPD = 15'h113; // tuning word update request
  localparam logic [14:0] ADDR_STAGE0 = 15'h114; // first staged tuning byte
  localparam int STAGE_BYTES = 8; // six tuning word bytes, two phase offset bytes
  localparam int TUNE_BYTES = 6; // bytes of the frequency tuning word

  // configuration field positions (each setting is mirrored in two bits)
  localparam int CFG_LSB_HI = 6; // lsb first, upper copy
  localparam int CFG_LSB_LO = 1; // lsb first, lower copy
  localparam int CFG_INC_HI = 5; // address increment, upper copy
  localparam int CFG_INC_LO = 2; // address increment, lower copy
  localparam int CFG_4W_HI = 4; // separate output pin active, upper copy
  localparam int CFG_4W_LO = 3; // separate output pin active, lower copy
  localparam int UPD_BIT = 0; // update request bit in its register

  // reset values
  localparam logic [7:0] CFG_RESET = 8'h00; // msb first, decrement, 3-wire
  localparam logic [7:0] STAGE_RESET = 8'h00; // staged and active tuning bytes

  // serial engine states, gray along idle -> instruction -> data
  typedef enum logic [1:0] {
    SRAP_IDLE = 2'b00,
    SRAP_INSTR = 2'b01,
    SRAP_DATA = 2'b11
  } srap_state_t;

endpackage : srap_pkg

// >>> hdl/srap_pin_sync.sv
`timescale 1ns/1ps
// ************************************************************
// pin synchroniser and serial clock edge finder
// ************************************************************
module srap_pin_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sclk_rise,
  output logic sclk_fall,
  output logic cs_n_s,
  output logic sdi_s
);

  logic [2:0] meta_reg; // first stage, read only by the second
  logic [2:0] sync_reg; // second stage: {sdi, cs_n, sclk}
  logic sclk_old_reg; // previous synced serial clock for edge finding

  // two flip-flops per pin; cs_n idles high so the port starts deselected
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 3'h2;
      sync_reg <= 3'h2;
      sclk_old_reg <= 1'b0;
    end else begin
      meta_reg <= {sdi, cs_n, sclk};
      sync_reg <= meta_reg;
      sclk_old_reg <= sync_reg[0];
    end
  end

  // data and clock share the same delay, so data is still valid at the edge
  assign sclk_rise = sync_reg[0] & ~sclk_old_reg;
  assign sclk_fall = ~sync_reg[0] & sclk_old_reg;
  assign cs_n_s = sync_reg[1];
  assign sdi_s = sync_reg[2];

endmodule : srap_pin_sync

// >>> hdl/srap_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - sixteen rising edges of instruction, then data
// - deselect then select restarts at instruction start
// - written byte takes effect at its last bit
// - tuning values apply only on update request
// - instruction bit fifteen high means read
// - instruction bits fourteen to zero start address
// - increment bits set: address plus one per byte
// - increment bits clear: address minus one per byte
// - reset gives 3-wire, 4-wire selectable
// - msb first or lsb first by configuration
// - lsb first: address, direction, then data
// - 4-wire read data leaves on separate pin
// - sample on rising, drive on falling edges
// - shared pin released while deselected
module srap_port (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n,
  output logic separate_serial_output_pin,
  output logic separate_serial_output_pin_oe_n,
  output logic [47:0] frequency_tuning_word,
  output logic [15:0] phase_offset,
  output logic lsb_first,
  output logic addr_increment,
  output logic four_wire,
  output logic busy
);

  // ************************************************************
  // pin sampling
  // ************************************************************
  logic sclk_rise; // one-cycle pulse on a serial clock rising edge
  logic sclk_fall; // one-cycle pulse on a serial clock falling edge
  logic cs_n_s; // synced chip select
  logic sdi_s; // synced serial input, aligned with the edges

  srap_pin_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdio_i),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .cs_n_s(cs_n_s),
    .sdi_s(sdi_s)
  );

  // ************************************************************
  // state
  // ************************************************************
  srap_pkg::srap_state_t state_reg, state_next; // serial engine phase
  logic [3:0] cnt_reg, cnt_next; // bit counter within phase
  logic [15:0] shift_reg, shift_next; // incoming bits
  logic rw_reg, rw_next; // latched direction, high for read
  logic [14:0] addr_reg, addr_next; // current register address
  logic [7:0] out_sr_reg, out_sr_next; // outgoing byte
  logic out_bit_reg, out_bit_next; // bit on the output pins
  logic [7:0] cfg_reg, cfg_next; // configuration byte
  logic [7:0] stage_reg [srap_pkg::STAGE_BYTES]; // staged tuning bytes
  logic [7:0] stage_next [srap_pkg::STAGE_BYTES];
  logic [7:0] act_reg [srap_pkg::STAGE_BYTES]; // tuning bytes in use
  logic [7:0] act_next [srap_pkg::STAGE_BYTES];

  logic [15:0] instr_in; // shift register with the current bit added
  logic [7:0] byte_in; // last eight bits in transfer order
  logic instr_done; // last instruction bit sampled
  logic byte_done; // last data bit of a byte sampled
  logic wr_strobe; // byte write commits now
  logic upd_strobe; // update request written with its bit set
  logic [14:0] addr_step; // address of the following byte

  // either copy of a mirrored setting enables it
  assign lsb_first = cfg_reg[srap_pkg::CFG_LSB_HI] | cfg_reg[srap_pkg::CFG_LSB_LO];
  assign addr_increment = cfg_reg[srap_pkg::CFG_INC_HI] | cfg_reg[srap_pkg::CFG_INC_LO];
  assign four_wire = cfg_reg[srap_pkg::CFG_4W_HI] | cfg_reg[srap_pkg::CFG_4W_LO];
  assign busy = (state_reg != srap_pkg::SRAP_IDLE);

  // ************************************************************
  // register decode
  // ************************************************************
  // staging window test, used for both reads and writes
  function automatic logic is_stage(input logic [14:0] a);
    is_stage = (a >= srap_pkg::ADDR_STAGE0) &&
      (a < srap_pkg::ADDR_STAGE0 + 15'(srap_pkg::STAGE_BYTES));
  endfunction : is_stage

  // read view; unmapped addresses and the update request read as zero
  function automatic logic [7:0] rd_byte(input logic [14:0] a);
    logic [14:0] idx;
    idx = a - srap_pkg::ADDR_STAGE0;
    if (a == srap_pkg::ADDR_CFG) begin
      rd_byte = cfg_reg;
    end else if (is_stage(a)) begin
      rd_byte = stage_reg[idx[2:0]];
    end else begin
      rd_byte = 8'h00;
    end
  endfunction : rd_byte

  // ************************************************************
  // serial engine and register file, next values
  // ************************************************************
  always_comb begin
    logic [14:0] widx;
    widx = addr_reg - srap_pkg::ADDR_STAGE0;
    // lsb first shifts right so the first bit ends lowest
    instr_in = lsb_first ? {sdi_s, shift_reg[15:1]} : {shift_reg[14:0], sdi_s};
    byte_in = lsb_first ? instr_in[15:8] : instr_in[7:0];
    instr_done = sclk_rise && !cs_n_s && (state_reg == srap_pkg::SRAP_INSTR) &&
      (cnt_reg == srap_pkg::INSTR_LAST);
    byte_done = sclk_rise && !cs_n_s && (state_reg == srap_pkg::SRAP_DATA) &&
      (cnt_reg == srap_pkg::BYTE_LAST);
    wr_strobe = byte_done && !rw_reg;
    upd_strobe = wr_strobe && (addr_reg == srap_pkg::ADDR_UPD) && byte_in[srap_pkg::UPD_BIT];
    addr_step = addr_increment ? addr_reg + 15'h0001 : addr_reg - 15'h0001;

    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    rw_next = rw_reg;
    addr_next = addr_reg;
    out_sr_next = out_sr_reg;
    out_bit_next = out_bit_reg;
    cfg_next = cfg_reg;
    stage_next = stage_reg;
    act_next = act_reg;

    if (cs_n_s) begin
      // deselect drops any partial transfer
      state_next = srap_pkg::SRAP_IDLE;
      cnt_next = 4'h0;
    end else begin
      case (state_reg)
        srap_pkg::SRAP_IDLE: begin
          // select seen; an edge in this very cycle is lost, setup time covers it
          state_next = srap_pkg::SRAP_INSTR;
          cnt_next = 4'h0;
        end
        srap_pkg::SRAP_INSTR: begin
          if (sclk_rise) begin
            shift_next = instr_in;
            cnt_next = cnt_reg + 4'h1;
            if (instr_done) begin
              state_next = srap_pkg::SRAP_DATA;
              cnt_next = 4'h0;
              rw_next = instr_in[srap_pkg::RW_BIT];
              addr_next = instr_in[14:0];
              out_sr_next = rd_byte(instr_in[14:0]);
            end
          end
        end
        srap_pkg::SRAP_DATA: begin
          if (sclk_rise) begin
            shift_next = instr_in;
            cnt_next = byte_done ? 4'h0 : cnt_reg + 4'h1;
            if (byte_done) begin
              addr_next = addr_step;
              out_sr_next = rd_byte(addr_step);
            end
          end else if (sclk_fall && rw_reg) begin
            // next read bit goes out on the falling edge
            out_bit_next = lsb_first ? out_sr_reg[0] : out_sr_reg[7];
            out_sr_next = lsb_first ? {1'b0, out_sr_reg[7:1]} : {out_sr_reg[6:0], 1'b0};
          end
        end
        default: begin
          state_next = srap_pkg::SRAP_IDLE;
        end
      endcase
    end

    // byte writes land at once, except tuning bytes which wait in staging
    if (wr_strobe) begin
      if (addr_reg == srap_pkg::ADDR_CFG) begin
        cfg_next = byte_in;
      end else if (is_stage(addr_reg)) begin
        stage_next[widx[2:0]] = byte_in;
      end
    end
    if (upd_strobe) begin
      act_next = stage_reg;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= srap_pkg::SRAP_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 16'h0000;
      rw_reg <= 1'b0;
      addr_reg <= 15'h0000;
      out_sr_reg <= 8'h00;
      out_bit_reg <= 1'b0;
      cfg_reg <= srap_pkg::CFG_RESET;
      for (int i = 0; i < srap_pkg::STAGE_BYTES; i++) begin
        stage_reg[i] <= srap_pkg::STAGE_RESET;
        act_reg[i] <= srap_pkg::STAGE_RESET;
      end
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      rw_reg <= rw_next;
      addr_reg <= addr_next;
      out_sr_reg <= out_sr_next;
      out_bit_reg <= out_bit_next;
      cfg_reg <= cfg_next;
      stage_reg <= stage_next;
      act_reg <= act_next;
    end
  end

  // ************************************************************
  // pin drivers and tuning outputs
  // ************************************************************
  // pins follow the select pin through sync delay only; released when deselected
  always_comb begin
    sdio_o = out_bit_reg;
    separate_serial_output_pin = out_bit_reg;
    sdio_oe_n = 1'b1;
    separate_serial_output_pin_oe_n = 1'b1;
    if (!cs_n_s && (state_reg == srap_pkg::SRAP_DATA) && rw_reg) begin
      if (four_wire) begin
        separate_serial_output_pin_oe_n = 1'b0;
      end else begin
        sdio_oe_n = 1'b0;
      end
    end
  end

  // byte 0 is least significant
  always_comb begin
    for (int i = 0; i < srap_pkg::TUNE_BYTES; i++) begin
      frequency_tuning_word[8*i +: 8] = act_reg[i];
    end
    phase_offset = {act_reg[srap_pkg::TUNE_BYTES + 1], act_reg[srap_pkg::TUNE_BYTES]};
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_cs_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_n_s |=> (state_reg == srap_pkg::SRAP_IDLE) && (cnt_reg == 4'h0))
    else $error("engine not idle after deselect");
  a_instr_length: assert property (@(posedge mclk) disable iff (!rst_n)
    (sclk_rise && !cs_n_s && state_reg == srap_pkg::SRAP_INSTR && cnt_reg != 4'hf)
      |=> state_reg == srap_pkg::SRAP_INSTR)
    else $error("instruction phase left early");
  a_instr_addr: assert property (@(posedge mclk) disable iff (!rst_n)
    instr_done |=> (addr_reg == $past(instr_in[14:0])) && (state_reg == srap_pkg::SRAP_DATA)
      && (rw_reg == $past(instr_in[15])))
    else $error("instruction not taken as address and direction");
  a_cfg_commit: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_strobe && addr_reg == srap_pkg::ADDR_CFG) |=> cfg_reg == $past(byte_in))
    else $error("configuration byte not written at last bit");
  a_tuning_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !$past(upd_strobe) |-> ($stable(frequency_tuning_word) && $stable(phase_offset)))
    else $error("tuning value changed without update request");
  a_addr_incr: assert property (@(posedge mclk) disable iff (!rst_n)
    (byte_done && addr_increment) |=> addr_reg == $past(addr_reg) + 15'h0001)
    else $error("address did not increment");
  a_addr_decr: assert property (@(posedge mclk) disable iff (!rst_n)
    (byte_done && !addr_increment) |=> addr_reg == $past(addr_reg) - 15'h0001)
    else $error("address did not decrement");
  a_lsb_order: assert property (@(posedge mclk) disable iff (!rst_n)
    (sclk_rise && !cs_n_s && state_reg == srap_pkg::SRAP_INSTR && lsb_first)
      |=> shift_reg[15] == $past(sdi_s))
    else $error("lsb first bit not entered at top");
  a_msb_order: assert property (@(posedge mclk) disable iff (!rst_n)
    (sclk_rise && !cs_n_s && state_reg == srap_pkg::SRAP_INSTR && !lsb_first)
      |=> shift_reg[0] == $past(sdi_s))
    else $error("msb first bit not entered at bottom");
  a_out_on_fall: assert property (@(posedge mclk) disable iff (!rst_n)
    !$past(sclk_fall) |-> $stable(out_bit_reg))
    else $error("output bit moved away from a falling edge");
  a_pin_release: assert property (@(posedge mclk) disable iff (!rst_n)
    (cs_n_s || !rw_reg || state_reg != srap_pkg::SRAP_DATA)
      |-> (sdio_oe_n && separate_serial_output_pin_oe_n))
    else $error("pin driven outside a read data phase");
  a_sep_pin: assert property (@(posedge mclk) disable iff (!rst_n)
    !separate_serial_output_pin_oe_n |-> (four_wire && sdio_oe_n))
    else $error("separate output pin driven in 3-wire mode");

endmodule : srap_port

// >>> bench/srap_ctrl_model.sv
`timescale 1ns/1ps
// ************************************************************
// system controller model, master of the serial link
// ************************************************************
module srap_ctrl_model (
  input wire logic sdio_w,
  input wire logic so_w,
  output logic sclk,
  output logic cs_n,
  output logic m_do,
  output logic m_oe
);
  logic [7:0] wr_q[$]; // bytes queued for write frames
  logic [7:0] rd_q[$]; // bytes captured by read frames

  // idle link: deselected, clock parked low, pin released
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    m_do = 1'b0;
    m_oe = 1'b0;
  end

  // one frame; low_ns stretches the low phase for a slow master,
  // stop cuts the frame after that many bits (0 runs it whole)
  task automatic frame(input logic rd, input logic [14:0] a, input int n, input logic lsb,
      input logic four, input int low_ns, input int stop);
    logic [7:0] d;
    int j;
    d = 8'h00;
    cs_n = 1'b0;
    m_oe = 1'b1;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      if (stop != 0 && i == stop) break;
      j = (i - 16) % 8;
      if (i >= 16 && j == 0) d = rd ? 8'h00 : wr_q.pop_front();
      if (i < 16) m_do = lsb ? (i < 15 ? a[i] : rd) : (i == 0 ? rd : a[15 - i]);
      else m_do = lsb ? d[j] : d[7 - j];
      #(low_ns);
      // read bit taken just before the rise, where the device has settled it
      if (rd && i >= 16) d[lsb ? j : 7 - j] = four ? so_w : sdio_w;
      sclk = 1'b1;
      #60;
      sclk = 1'b0;
      if (rd && !four && i == 15) m_oe = 1'b0;
      if (rd && i >= 16 && j == 7) rd_q.push_back(d);
    end
    #40;
    cs_n = 1'b1;
    m_oe = 1'b0;
  endtask : frame
endmodule : srap_ctrl_model

// >>> bench/test_serial_register_access_port.sv
`timescale 1ns/1ps
// ************************************************************
// self-checking bench for the serial register access port
// ************************************************************
module test_serial_register_access_port;
  logic mclk, rst_n, sclk, cs_n, m_do, m_oe, float_q, bad4;
  logic sdio_o, sdio_oe_n, so, so_oe_n, lsb_first, addr_increment, four_wire, busy;
  logic [47:0] tune_word;
  logic [15:0] phase;
  logic [7:0] cfg_e, v;
  logic [7:0] stg[8]; // expected staged bytes
  logic [47:0] exp_tune;
  logic [15:0] exp_ph;
  logic lsb_e, inc_e, four_e;
  logic sdio_w, so_w;
  int err_total, n_checks;

  // both driving shows x so a pin fight can never read as good data;
  // a released pin toggles every cycle instead of keeping its last value
  assign sdio_w = (!sdio_oe_n && m_oe) ? 1'bx : !sdio_oe_n ? sdio_o : m_oe ? m_do : float_q;
  assign so_w = !so_oe_n ? so : float_q;
  assign lsb_e = cfg_e[6] | cfg_e[1];
  assign inc_e = cfg_e[5] | cfg_e[2];
  assign four_e = cfg_e[4] | cfg_e[3];

  srap_port i_dut (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_w),
    .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n), .separate_serial_output_pin(so),
    .separate_serial_output_pin_oe_n(so_oe_n), .frequency_tuning_word(tune_word),
    .phase_offset(phase), .lsb_first(lsb_first), .addr_increment(addr_increment),
    .four_wire(four_wire), .busy(busy));
  srap_ctrl_model i_ctrl (.sdio_w(sdio_w), .so_w(so_w), .sclk(sclk), .cs_n(cs_n),
    .m_do(m_do), .m_oe(m_oe));

  // 50 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // float pattern, and a sticky flag for a shared pin driven in 4-wire mode
  always @(posedge mclk) begin
    float_q <= (float_q === 1'b0);
    if (!rst_n) bad4 <= 1'b0;
    else if (four_wire === 1'b1 && sdio_oe_n === 1'b0) bad4 <= 1'b1;
  end

  // verdict, the only place the run ends
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [14:0] step(input logic [14:0] a);
    return inc_e ? a + 15'h0001 : a - 15'h0001;
  endfunction : step

  function automatic logic [7:0] exp_rd(input logic [14:0] a);
    if (a == 15'h000) return cfg_e;
    if (a >= 15'h114 && a <= 15'h11b) return stg[a - 15'h114];
    return 8'h00; // unmapped and the update request read zero
  endfunction : exp_rd

  // deselect gap; the pins must be released once cs_n is seen high
  task automatic gap;
    #200;
    chk("sdio_oe_n idle", 1, sdio_oe_n);
    chk("so_oe_n idle", 1, so_oe_n);
    chk("busy idle", 0, busy);
  endtask : gap

  // write the queued bytes from a, tracking what the device must hold
  task automatic wr(input logic [14:0] a, input int low_ns);
    logic [14:0] p;
    logic l, f;
    int n;
    p = a;
    l = lsb_e;
    f = four_e;
    n = i_ctrl.wr_q.size();
    for (int i = 0; i < n; i++) begin
      v = i_ctrl.wr_q[i];
      if (p == 15'h000) cfg_e = v;
      if (p >= 15'h114 && p <= 15'h11b) stg[p - 15'h114] = v;
      if (p == 15'h113 && v[0]) exp_tune = {stg[5], stg[4], stg[3], stg[2], stg[1], stg[0]};
      if (p == 15'h113 && v[0]) exp_ph = {stg[7], stg[6]};
      p = step(p);
    end
    i_ctrl.frame(1'b0, a, n, l, f, low_ns, 0);
  endtask : wr

  task automatic rd(input logic [14:0] a, input int n, input int low_ns);
    logic [14:0] p;
    p = a;
    i_ctrl.rd_q.delete();
    i_ctrl.frame(1'b1, a, n, lsb_e, four_e, low_ns, 0);
    for (int i = 0; i < n; i++) begin
      chk("read byte", exp_rd(p), i_ctrl.rd_q[i]);
      p = step(p);
    end
    gap();
  endtask : rd

  // stage eight random bytes from a, then request the update
  task automatic load(input logic [14:0] a);
    for (int i = 0; i < 8; i++) i_ctrl.wr_q.push_back($urandom);
    wr(a, 100);
    chk("tuning word held", exp_tune, tune_word);
    gap();
    i_ctrl.wr_q.push_back(8'h01);
    wr(15'h113, 100);
    chk("tuning word applied", exp_tune, tune_word);
    chk("phase applied", exp_ph, phase);
    gap();
  endtask : load

  // hang guard
  initial begin
    #1ms;
    err_total++;
    $display("ERROR watchdog expected done seen hang");
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    cfg_e = 8'h00;
    exp_tune = 48'h0;
    exp_ph = 16'h0;
    err_total = 0;
    n_checks = 0;
    foreach (stg[i]) stg[i] = 8'h00;
    void'($urandom(79));
    repeat (20) @(posedge mclk);
    #2 rst_n = 1'b1;
    #200;
    chk("four_wire reset", 0, four_wire);
    chk("lsb_first reset", 0, lsb_first);
    chk("addr_increment reset", 0, addr_increment);
    chk("tuning word reset", 0, tune_word);
    chk("sdio_oe_n reset", 1, sdio_oe_n);
    $display("test reset done");
    load(15'h11b);
    rd(15'h11b, 8, 100);
    rd(15'h114, 3, 400);
    $display("test msb decrement done");
    v = $urandom;
    i_ctrl.wr_q.push_back((v[0] ? 8'h40 : 8'h02) | (v[1] ? 8'h20 : 8'h04));
    wr(15'h000, 100);
    chk("lsb_first set", 1, lsb_first);
    chk("addr_increment set", 1, addr_increment);
    gap();
    load(15'h114);
    rd(15'h112, 5, 100);
    rd(15'h000, 1, 100);
    $display("test lsb increment done");
    i_ctrl.wr_q.push_back(8'ha5);
    i_ctrl.frame(1'b0, 15'h114, 1, lsb_e, four_e, 100, 1 + $urandom % 23);
    i_ctrl.wr_q.delete();
    gap();
    rd(15'h114, 1, 100);
    $display("test abort done");
    v = $urandom;
    i_ctrl.wr_q.push_back(cfg_e | (v[0] ? 8'h10 : 8'h08));
    wr(15'h000, 100);
    chk("four_wire set", 1, four_wire);
    gap();
    rd(15'h11a, 3, 100);
    chk("shared pin quiet", 0, bad4);
    $display("test four wire done");
    wrap_up();
  end
endmodule : test_serial_register_access_port
